//--- shared/reset_sequence_and_supply_guard_pkg.sv
// Constants, types and register map of the reset sequencer and supply
// guard. Assumes a 100 MHz pclk and an APB master with 32-bit data.
package reset_sequence_and_supply_guard_pkg;

  // Non-volatile option settings, sampled in the active reset phase
  typedef struct packed {
    logic long_delay;
    logic lvd_en;
    logic [1:0] lvd_level;
    logic pll_en;
  } opt_t;

  typedef struct packed {
    logic o;
    logic oe;
  } pin_drv_t;

  typedef enum logic [1:0] {
    SEQ_RUN = 2'b00,
    SEQ_ACTIVE = 2'b01,
    SEQ_DELAY = 2'b10,
    SEQ_FETCH = 2'b11
  } seq_t;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ = 100;
  localparam int MIN_RESET_OUT_NS = 1000;
  localparam logic [12:0] MIN_OUT_CYC =
    13'((MIN_RESET_OUT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [12:0] SHORT_DELAY_CYC = 13'd256;
  localparam logic [12:0] LONG_DELAY_CYC = 13'd4096;
  localparam logic [12:0] FETCH_CYC = 13'd2;
  localparam logic [7:0] OSC_LOSS_CYC = 8'd64;
  localparam logic [15:0] RESET_VECTOR = 16'hfffe;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] OPTION_OFS = 8'h08;
  localparam int CTRL_WARN_IE_BIT = 0;
  localparam int CTRL_CLKF_IE_BIT = 1;
  localparam int ST_WARN_FLAG_BIT = 0;
  localparam int ST_WARN_PEND_BIT = 1;
  localparam int ST_CLKF_FLAG_BIT = 2;
  localparam int ST_SAFE_SEL_BIT = 3;
  localparam logic [1:0] CTRL_RESET = 2'h0;

endpackage : reset_sequence_and_supply_guard_pkg

//--- design/level_sync.sv
// Three-stage synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to pclk.
`timescale 1ns/1ps
module level_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  // A change counts only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      q <= INIT;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q <= s3_r;
      end
    end
  end

endmodule : level_sync

//--- design/reset_sequence_and_supply_guard.sv
// Reset sequencer, supply guard and clock guard with an APB slave.
// Assumes analog comparators and the oscillator arrive as async levels,
// the watchdog pulse and CPU interrupt mask come from pclk logic.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module reset_sequence_and_supply_guard
  import reset_sequence_and_supply_guard_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire opt_t opt_in,
  input wire logic rst_pin_i,
  output pin_drv_t rst_pin,
  input wire logic lvd_below,
  input wire logic avd_below,
  input wire logic wdg_underflow,
  input wire logic osc_clock,
  input wire logic cpu_irq_mask,
  output logic cpu_reset_n,
  output logic fetch_valid,
  output logic [15:0] fetch_addr,
  output logic lvd_rising_sel,
  output logic [1:0] lvd_level_sel,
  output logic avd_en,
  output logic avd_rising_sel,
  output logic [1:0] avd_level_sel,
  output logic osc_filt,
  output logic safe_osc_sel,
  output logic warn_irq,
  output logic clkf_irq
);

  // ************************************************************
  // Declarations
  // ************************************************************
  seq_t state_r, state_nxt;
  logic [12:0] cnt_r, delay_cyc;
  opt_t opt_r;
  logic ext_req_r, ext_arm_n, ext_s, lvd_s, avd_s, osc_s;
  logic [3:0] sync_d, sync_q;
  logic wdg_req_r, lvd_cause, cause, drive_r;
  logic warn_flag, warn_prev_r, warn_pend_r, warn_ie_r;
  logic clkf_ie_r, clkf_flag_r, osc_prev_r;
  logic [1:0] osc_hold_r;
  logic [7:0] idle_cnt_r;
  logic setup, wr_ctrl, wr_status, rd_status;

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  // The pin only retriggers while we are not pulling it ourselves
  assign ext_arm_n = rst_pin_i | drive_r;

  // Async capture works with pclk stopped; cleared once acted on
  always_ff @(posedge pclk or negedge ext_arm_n) begin
    if (!ext_arm_n) begin
      ext_req_r <= 1'b1;
    end else if (state_r == SEQ_ACTIVE && ext_s) begin
      ext_req_r <= 1'b0;
    end
  end

  // Ext request and low voltage start high so a cause stands at first
  assign sync_d = {osc_clock, avd_below, lvd_below, ext_req_r};
  for (genvar i = 0; i < 4; i++) begin : g_sync
    level_sync #(.INIT(i < 2)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(sync_d[i]),
      .q(sync_q[i])
    );
  end
  assign {osc_s, avd_s, lvd_s, ext_s} = sync_q;

  // ************************************************************
  // Option settings
  // ************************************************************
  // Taken while the sequencer is in SEQ_ACTIVE, frozen through delay, fetch and run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_r <= '0;
    end else if (state_r == SEQ_ACTIVE) begin
      opt_r <= opt_in;
    end
  end

  assign lvd_cause = opt_r.lvd_en & lvd_s;
  assign cause = ext_s | lvd_cause | wdg_req_r;
  assign delay_cyc = opt_r.long_delay ? LONG_DELAY_CYC
                                      : SHORT_DELAY_CYC;

  // ************************************************************
  // Watchdog request
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdg_req_r <= 1'b0;
    end else if (wdg_underflow) begin
      wdg_req_r <= 1'b1;
    end else if (state_r == SEQ_ACTIVE) begin
      wdg_req_r <= 1'b0;
    end
  end

  // ************************************************************
  // Reset sequencer
  // ************************************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SEQ_RUN: begin
        if (cause) begin
          state_nxt = SEQ_ACTIVE;
        end
      end
      SEQ_ACTIVE: begin
        // Minimum width holds even for a short external pulse
        if (!cause && cnt_r >= MIN_OUT_CYC - 13'd1) begin
          state_nxt = SEQ_DELAY;
        end
      end
      SEQ_DELAY: begin
        if (cause) begin
          state_nxt = SEQ_ACTIVE;
        end else if (cnt_r == delay_cyc - 13'd1) begin
          state_nxt = SEQ_FETCH;
        end
      end
      SEQ_FETCH: begin
        if (cause) begin
          state_nxt = SEQ_ACTIVE;
        end else if (cnt_r == FETCH_CYC - 13'd1) begin
          state_nxt = SEQ_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SEQ_ACTIVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // One counter serves the width, delay and fetch phases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (state_nxt != state_r) begin
      cnt_r <= '0;
    end else if (state_r == SEQ_ACTIVE) begin
      if (cnt_r < MIN_OUT_CYC) begin
        cnt_r <= cnt_r + 13'd1;
      end
    end else if (state_r != SEQ_RUN) begin
      cnt_r <= cnt_r + 13'd1;
    end
  end

  // ************************************************************
  // Reset pin and CPU side
  // ************************************************************
  // Open drain: the output level is always low, only enable moves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_r <= 1'b1;
      rst_pin <= '{o: 1'b0, oe: 1'b1};
    end else begin
      // Guard lags the release one edge: the rising pin is no new pulse
      drive_r <= (state_nxt == SEQ_ACTIVE)
               | (state_nxt == SEQ_DELAY)
               | rst_pin.oe;
      rst_pin <= '{o: 1'b0,
                   oe: (state_nxt == SEQ_ACTIVE)
                     | (state_nxt == SEQ_DELAY)};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_reset_n <= 1'b0;
      fetch_valid <= 1'b0;
      fetch_addr <= RESET_VECTOR;
    end else begin
      cpu_reset_n <= (state_nxt == SEQ_RUN);
      fetch_valid <= (state_nxt == SEQ_FETCH);
      if (state_nxt == SEQ_FETCH && state_r == SEQ_FETCH) begin
        fetch_addr <= RESET_VECTOR | 16'h0001;
      end else begin
        fetch_addr <= RESET_VECTOR;
      end
    end
  end

  // ************************************************************
  // Voltage detector controls
  // ************************************************************
  // Rising threshold while held in reset, falling while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvd_rising_sel <= 1'b1;
      lvd_level_sel <= '0;
      avd_en <= 1'b0;
      avd_rising_sel <= 1'b1;
      avd_level_sel <= '0;
    end else begin
      lvd_rising_sel <= (state_nxt != SEQ_RUN);
      lvd_level_sel <= opt_r.lvd_level;
      avd_en <= opt_r.lvd_en;
      avd_rising_sel <= warn_flag;
      avd_level_sel <= opt_r.lvd_level;
    end
  end

  // ************************************************************
  // Supply warning
  // ************************************************************
  assign warn_flag = opt_r.lvd_en & avd_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_prev_r <= 1'b0;
    end else begin
      warn_prev_r <= warn_flag;
    end
  end

  // Crossings during reset are tracked but never reported
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_pend_r <= 1'b0;
    end else if (state_r != SEQ_RUN) begin
      warn_pend_r <= 1'b0;
    end else if (warn_ie_r && warn_flag != warn_prev_r) begin
      warn_pend_r <= 1'b1;
    end else if (wr_ctrl && !warn_ie_r && warn_flag
                 && pwdata[CTRL_WARN_IE_BIT]) begin
      warn_pend_r <= 1'b1;
    end else if (wr_status && pwdata[ST_WARN_PEND_BIT]) begin
      warn_pend_r <= 1'b0;
    end
  end

  // ************************************************************
  // Clock guard
  // ************************************************************
  // With the PLL a level must hold three samples; lone spikes vanish
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_hold_r <= '0;
      osc_filt <= 1'b0;
    end else begin
      osc_hold_r <= {osc_hold_r[0], osc_s};
      if (!opt_r.pll_en) begin
        osc_filt <= osc_s;
      end else if (osc_hold_r == {2{osc_s}}) begin
        osc_filt <= osc_s;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev_r <= 1'b0;
      idle_cnt_r <= '0;
      safe_osc_sel <= 1'b0;
    end else begin
      osc_prev_r <= osc_filt;
      if (osc_filt != osc_prev_r) begin
        idle_cnt_r <= '0;
        safe_osc_sel <= 1'b0;
      end else if (idle_cnt_r < OSC_LOSS_CYC) begin
        idle_cnt_r <= idle_cnt_r + 8'd1;
      end else begin
        safe_osc_sel <= 1'b1;
      end
    end
  end

  // Set wins over the clear-on-read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clkf_flag_r <= 1'b0;
    end else if (safe_osc_sel) begin
      clkf_flag_r <= 1'b1;
    end else if (rd_status) begin
      clkf_flag_r <= 1'b0;
    end
  end

  // ************************************************************
  // Interrupt requests
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_irq <= 1'b0;
      clkf_irq <= 1'b0;
    end else begin
      warn_irq <= warn_pend_r & warn_ie_r & ~cpu_irq_mask;
      clkf_irq <= clkf_flag_r & clkf_ie_r & ~cpu_irq_mask;
    end
  end

  // ************************************************************
  // APB slave
  // ************************************************************
  // Zero wait states: read data is prepared in the setup cycle
  assign setup = psel & ~penable;
  assign wr_ctrl = psel & penable & pwrite & hit(paddr, CTRL_OFS);
  assign wr_status = psel & penable & pwrite & hit(paddr, STATUS_OFS);
  assign rd_status = psel & penable & ~pwrite & hit(paddr, STATUS_OFS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_ie_r <= CTRL_RESET[CTRL_WARN_IE_BIT];
      clkf_ie_r <= CTRL_RESET[CTRL_CLKF_IE_BIT];
    end else if (wr_ctrl) begin
      warn_ie_r <= pwdata[CTRL_WARN_IE_BIT];
      clkf_ie_r <= pwdata[CTRL_CLKF_IE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata <= '0;
        pslverr <= 1'b0;
        if (hit(paddr, CTRL_OFS)) begin
          prdata[CTRL_WARN_IE_BIT] <= warn_ie_r;
          prdata[CTRL_CLKF_IE_BIT] <= clkf_ie_r;
        end else if (hit(paddr, STATUS_OFS)) begin
          prdata[ST_WARN_FLAG_BIT] <= warn_flag;
          prdata[ST_WARN_PEND_BIT] <= warn_pend_r;
          prdata[ST_CLKF_FLAG_BIT] <= clkf_flag_r;
          prdata[ST_SAFE_SEL_BIT] <= safe_osc_sel;
        end else if (hit(paddr, OPTION_OFS)) begin
          prdata[$bits(opt_t)-1:0] <= opt_r;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

endmodule : reset_sequence_and_supply_guard

//--- verification/ext_reset_model.sv
// Far-side reset circuitry sharing the open-drain reset wire.
// Assumes the device pulls the wire only while its drive enable is high.
`timescale 1ns/1ps
module ext_reset_model
  import reset_sequence_and_supply_guard_pkg::*;
(
  input wire logic pull,
  input wire pin_drv_t drv,
  output logic pin
);
  // Wired-and with a weak pull-up: a released wire reads high
  assign pin = !(pull || (drv.oe && !drv.o));
endmodule : ext_reset_model

//--- verification/seq_guard_assertions.sv
// Checker for the reset sequencer and supply guard top ports.
// Assumes the bench holds the option straps steady through a sequence.
`timescale 1ns/1ps
module seq_guard_checker
  import reset_sequence_and_supply_guard_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire opt_t opt_in,
  input wire pin_drv_t rst_pin,
  input wire logic lvd_below,
  input wire logic wdg_underflow,
  input wire logic cpu_irq_mask,
  input wire logic cpu_reset_n,
  input wire logic fetch_valid,
  input wire logic [15:0] fetch_addr,
  input wire logic lvd_rising_sel,
  input wire logic [1:0] lvd_level_sel,
  input wire logic [1:0] avd_level_sel,
  input wire logic avd_en,
  input wire logic warn_irq,
  input wire logic clkf_irq
);
  int oe_cnt;

  // Counts how long the device has pulled the wire in one stretch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_cnt <= 0;
    end else begin
      oe_cnt <= rst_pin.oe ? oe_cnt + 1 : 0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pin_low_a: assert property (!cpu_reset_n && !fetch_valid &&
    !$past(fetch_valid) |-> rst_pin.oe) else $error("pin released early");
  fetch_pair_a: assert property ($rose(fetch_valid) |->
    fetch_addr == RESET_VECTOR ##1 (fetch_valid && fetch_addr == 16'hffff)
    ##1 !fetch_valid) else $error("vector fetch wrong");
  wdg_start_a: assert property (cpu_reset_n && wdg_underflow |->
    ##[1:2] (!cpu_reset_n && rst_pin.oe)) else $error("no wdg reset");
  min_width_a: assert property ($fell(rst_pin.oe) |-> oe_cnt >=
    int'(MIN_OUT_CYC) + (opt_in.long_delay ? int'(LONG_DELAY_CYC) :
    int'(SHORT_DELAY_CYC))) else $error("reset too short");
  lvd_hold_a: assert property (opt_in.lvd_en && lvd_below [*8] |->
    !cpu_reset_n && rst_pin.oe) else $error("lvd not holding");
  mask_a: assert property ($past(cpu_irq_mask) |->
    !warn_irq && !clkf_irq) else $error("irq while masked");
  warn_off_a: assert property (!avd_en && $past(avd_en) == 1'h0 |->
    !warn_irq) else $error("warning irq while off");
  level_track_a: assert property (avd_level_sel == lvd_level_sel)
    else $error("warning level differs");
  rising_sel_a: assert property (cpu_reset_n == $past(cpu_reset_n) |->
    lvd_rising_sel == !cpu_reset_n) else $error("threshold select wrong");

  cover property ($rose(fetch_valid));
  cover property ($rose(warn_irq));
  cover property ($rose(clkf_irq));
endmodule : seq_guard_checker

bind reset_sequence_and_supply_guard seq_guard_checker chk_i (
  .pclk, .presetn, .opt_in, .rst_pin, .lvd_below, .wdg_underflow,
  .cpu_irq_mask, .cpu_reset_n, .fetch_valid, .fetch_addr, .lvd_rising_sel,
  .lvd_level_sel, .avd_level_sel, .avd_en, .warn_irq, .clkf_irq
);

//--- verification/tb.sv
// Self-checking bench: APB register tests and reset scenarios.
// Assumes the package constants and the bound checker are compiled first.
`timescale 1ns/1ps
module tb;
  import reset_sequence_and_supply_guard_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, rst_pin_i, lvd_below = 0, avd_below = 0;
  logic wdg_underflow = 0, osc_clock = 0, cpu_irq_mask = 0, ext_pull = 0;
  logic osc_run = 1, cpu_reset_n, fetch_valid, lvd_rising_sel, avd_en;
  logic avd_rising_sel, osc_filt, safe_osc_sel, warn_irq, clkf_irq, lv;
  logic [15:0] fetch_addr;
  logic [1:0] lvd_level_sel, avd_level_sel;
  logic [2:0] ev;
  logic [4:0] oc = 5'h00;
  logic osc_gl = 1'h0;
  opt_t opt_in = '{1'h0, 1'h1, 2'h2, 1'h1};
  pin_drv_t rst_pin;
  int num_errors = 0, tests_run = 0, n;

  always #5 pclk = ~pclk;
  assign ev = {clkf_irq, safe_osc_sel, warn_irq};

  reset_sequence_and_supply_guard dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .opt_in, .rst_pin_i, .rst_pin, .lvd_below,
    .avd_below, .wdg_underflow, .osc_clock(osc_clock ^ osc_gl),
    .cpu_irq_mask, .cpu_reset_n,
    .fetch_valid, .fetch_addr, .lvd_rising_sel, .lvd_level_sel, .avd_en,
    .avd_rising_sel, .avd_level_sel, .osc_filt, .safe_osc_sel,
    .warn_irq, .clkf_irq
  );
  ext_reset_model pm (.pull(ext_pull), .drv(rst_pin), .pin(rst_pin_i));

  // Oscillator at one twentieth of pclk, far below the filter's limit
  always @(posedge pclk) begin
    oc <= (oc == 5'h09) ? 5'h00 : oc + 5'h01;
    if (osc_run && oc == 5'h09) osc_clock <= ~osc_clock;
  end

  // ******************************
  // Tasks
  // ******************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask : tick

  // One idle edge at the end keeps back-to-back calls single-driven
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask : apb

  task automatic seq(output int t);
    t = 0;
    while (cpu_reset_n !== 1'h1 && t < 9000) begin
      @(posedge pclk);
      t++;
    end
  endtask : seq

  task automatic wait_hi(input int s);
    int k;
    k = 0;
    while (ev[s] !== 1'h1 && k < 200) begin
      @(posedge pclk);
      k++;
    end
  endtask : wait_hi

  task automatic pulse_wdg();
    wdg_underflow <= 1'h1;
    tick(1);
    wdg_underflow <= 1'h0;
  endtask : pulse_wdg

  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // ******************************
  // Scenarios
  // ******************************
  initial begin
    tick(10);
    presetn <= 1'h1;
    seq(n);
    chk(n >= 356 && n <= 368, 1'h1);
    apb(1'h0, OPTION_OFS, 32'h0);
    chk(rd, 32'h0d);
    apb(1'h1, CTRL_OFS, 32'hffffffff);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(rd, 32'h3);
    apb(1'h1, 8'h0c, 32'hffffffff);
    chk(er, 1'h1);
    apb(1'h0, 8'h0c, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    chk(avd_level_sel, 2'h2);
    apb(1'h1, CTRL_OFS, 32'h0);
    // Watchdog with long delay and the detector switched off
    opt_in <= '{1'h1, 1'h0, 2'h1, 1'h1};
    pulse_wdg();
    tick(50);
    chk(rst_pin_i, 1'h0);
    seq(n);
    chk(n >= 4144 && n <= 4160, 1'h1);
    apb(1'h0, OPTION_OFS, 32'h0);
    chk(rd, 32'h13);
    chk(avd_en, 1'h0);
    lvd_below <= 1'h1;
    avd_below <= 1'h1;
    apb(1'h1, CTRL_OFS, 32'h1);
    tick(12);
    chk(cpu_reset_n, 1'h1);
    chk(warn_irq, 1'h0);
    lvd_below <= 1'h0;
    avd_below <= 1'h0;
    // Supply drop during the active phase holds it; the delay runs after release
    opt_in <= '{1'h0, 1'h1, 2'h3, 1'h1};
    pulse_wdg();
    tick(20);
    lvd_below <= 1'h1;
    tick(300);
    chk(rst_pin_i, 1'h0);
    chk(lvd_rising_sel, 1'h1);
    lvd_below <= 1'h0;
    seq(n);
    chk(n >= 256 && n <= 272, 1'h1);
    chk(lvd_level_sel, 2'h3);
    // Short external pulse is stretched by the device
    ext_pull <= 1'h1;
    tick(3);
    ext_pull <= 1'h0;
    tick(40);
    chk(rst_pin.oe, 1'h1);
    chk(rst_pin_i, 1'h0);
    seq(n);
    chk(n >= 305 && n <= 330, 1'h1);
    // Warning interrupts on both edges, masked, then late enable
    apb(1'h1, CTRL_OFS, 32'h1);
    avd_below <= 1'h1;
    wait_hi(0);
    chk(warn_irq, 1'h1);
    chk(avd_rising_sel, 1'h1);
    apb(1'h0, STATUS_OFS, 32'h0);
    chk(rd[1:0], 2'h3);
    apb(1'h1, STATUS_OFS, 32'h2);
    tick(1);
    chk(warn_irq, 1'h0);
    cpu_irq_mask <= 1'h1;
    avd_below <= 1'h0;
    tick(12);
    chk(warn_irq, 1'h0);
    apb(1'h0, STATUS_OFS, 32'h0);
    chk(rd[1:0], 2'h2);
    cpu_irq_mask <= 1'h0;
    wait_hi(0);
    chk(warn_irq, 1'h1);
    apb(1'h1, STATUS_OFS, 32'h2);
    apb(1'h1, CTRL_OFS, 32'h0);
    avd_below <= 1'h1;
    tick(12);
    chk(warn_irq, 1'h0);
    apb(1'h1, CTRL_OFS, 32'h1);
    wait_hi(0);
    chk(warn_irq, 1'h1);
    apb(1'h1, STATUS_OFS, 32'h2);
    tick(1);
    avd_below <= 1'h0;
    wait_hi(0);
    chk(warn_irq, 1'h1);
    apb(1'h1, STATUS_OFS, 32'h2);
    // Oscillator loss, glitch filtering and recovery
    apb(1'h1, CTRL_OFS, 32'h2);
    osc_run <= 1'h0;
    wait_hi(1);
    chk(safe_osc_sel, 1'h1);
    wait_hi(2);
    chk(clkf_irq, 1'h1);
    apb(1'h0, STATUS_OFS, 32'h0);
    chk(rd[3:2], 2'h3);
    lv = osc_clock;
    // Two high samples pass the synchroniser; only the filter stops them
    osc_gl <= 1'h1;
    tick(2);
    osc_gl <= 1'h0;
    tick(4);
    chk(osc_filt, lv);
    osc_run <= 1'h1;
    tick(80);
    chk(safe_osc_sel, 1'h0);
    close_out();
  end

  // Whole run is near 6000 cycles; this limit leaves ample margin
  initial begin
    tick(30000);
    num_errors++;
    close_out();
  end
endmodule : tb
